// ===== sim/ipc_testbench.sv
// Self-checking testbench of the priority configuration block.
`timescale 1ns/1ps
module testbench;
    logic        clk_in                    = 1'b0;
    logic        resetn_in                 = 1'b0;
    logic [3:0]  addr_in                   = 4'h0;
    logic [15:0] wdata_in                  = 16'h0000;
    logic        wr_in                     = 1'b0;
    logic        rd_in                     = 1'b0;
    logic [19:0] src_req_in                = 20'h00000;
    logic [7:0]  src_vector_base_in        = 8'h10;
    logic [15:0] rdata_out;
    logic [3:0]  new_cpu_level_out;
    logic [6:0]  pending_vector_number_out;
    logic        irq_pending_out;
    int          error_cnt                 = 0;
    int          compares                  = 0;
    logic [15:0] mask [7] = '{16'h7700, 16'h7777, 16'h7777, 16'h0077, 16'h7700, 16'h7777, 16'h0077};

    ipc_prio_config dut (
        .clk_in                    (clk_in),
        .resetn_in                 (resetn_in),
        .addr_in                   (addr_in),
        .wdata_in                  (wdata_in),
        .wr_in                     (wr_in),
        .rd_in                     (rd_in),
        .rdata_out                 (rdata_out),
        .src_req_in                (src_req_in),
        .src_vector_base_in        (src_vector_base_in),
        .new_cpu_level_out         (new_cpu_level_out),
        .pending_vector_number_out (pending_vector_number_out),
        .irq_pending_out           (irq_pending_out)
    );

    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        #1 d = rdata_out;
    endtask

    task automatic test_reset;
        logic [15:0] d;
        for (int i = 0; i < 7; i++) begin
            bus_rd(i[3:0], d);
            check("prio reset", d, mask[i] & 16'h4444);
        end
        bus_rd(ipc_pkg::OFS_STATUS, d);
        check("status reset", d, 16'h0000);
        bus_rd(4'h9, d);
        check("unmapped read", d, 16'h0000);
        $display("test_reset done");
    endtask

    task automatic test_regs;
        logic [15:0] d;
        for (int i = 0; i < 7; i++) begin
            bus_wr(i[3:0], 16'hFFFF);
            bus_rd(i[3:0], d);
            check("all ones", d, mask[i]);
            bus_wr(i[3:0], 16'hF6D2);
            bus_rd(i[3:0], d);
            check("field pattern", d, mask[i] & 16'hF6D2);
            @(posedge clk_in);
            #1 check("rdata idle", rdata_out, 16'h0000);
            bus_wr(i[3:0], 16'h4444);
        end
        bus_wr(ipc_pkg::OFS_STATUS, 16'hFFFF);
        bus_rd(ipc_pkg::OFS_STATUS, d);
        check("status write", d, 16'h0000);
        $display("test_regs done");
    endtask

    task automatic arb(input logic [19:0] req, input logic [3:0] lv, input logic [6:0] vc, input logic ip);
        logic [15:0] d;
        @(posedge clk_in);
        src_req_in <= req;
        repeat (2) @(posedge clk_in);
        #1 check("level", {12'h000, new_cpu_level_out}, {12'h000, lv});
        check("vector", {9'h000, pending_vector_number_out}, {9'h000, vc});
        check("pending", {15'h0000, irq_pending_out}, {15'h0000, ip});
        bus_rd(ipc_pkg::OFS_STATUS, d);
        check("status", d, {4'h0, lv, 1'b0, vc});
    endtask

    task automatic test_arb;
        bus_wr(ipc_pkg::OFS_PWM_A, 16'h4000);
        bus_wr(ipc_pkg::OFS_ADC_A, 16'h4700);
        arb(20'h01021, 4'h7, 7'h14, 1'b1);
        arb(20'h00001, 4'h7, 7'h14, 1'b0);
        arb(20'h00028, 4'h4, 7'h0B, 1'b1);
        bus_wr(ipc_pkg::OFS_PWM_B, 16'h1020);
        arb(20'h00028, 4'h2, 7'h0B, 1'b1);
        bus_wr(ipc_pkg::OFS_PWM_B, 16'h7020);
        arb(20'h00028, 4'h7, 7'h0D, 1'b1);
        $display("test_arb done");
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        test_reset();
        test_regs();
        test_arb();
        close_out();
    end
endmodule // testbench

// ===== src/ipc_pkg.sv
// Package with register map, field layout and reset values of the priority configuration block.
package ipc_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    localparam int          PRIO_W          = 3;
    localparam int          NUM_SRC         = 20;
    localparam logic [3:0]  OFS_PWM_A       = 4'h0;
    localparam logic [3:0]  OFS_PWM_B       = 4'h1;
    localparam logic [3:0]  OFS_PWM_CMP     = 4'h2;
    localparam logic [3:0]  OFS_CMP         = 4'h3;
    localparam logic [3:0]  OFS_ADC_A       = 4'h4;
    localparam logic [3:0]  OFS_ADC_B       = 4'h5;
    localparam logic [3:0]  OFS_ADC_C       = 4'h6;
    localparam logic [3:0]  OFS_STATUS      = 4'h7;
    localparam int          FLD0_LSB        = 0;
    localparam int          FLD1_LSB        = 4;
    localparam int          FLD2_LSB        = 8;
    localparam int          FLD3_LSB        = 12;
    localparam logic [2:0]  PRIO_RESET      = 3'h4;
    localparam logic [2:0]  PRIO_OFF        = 3'h0;
    localparam int          LEVEL_LSB       = 8;
    localparam int          VEC_LSB         = 0;
    localparam logic [3:0]  LEVEL_RESET     = 4'h0;
    localparam logic [6:0]  VEC_RESET       = 7'h00;
    localparam logic [7:0]  VEC_BASE        = 8'h08;
    localparam logic [15:0] MASK_FOUR       = 16'h7777;
    localparam logic [15:0] MASK_HIGH_TWO   = 16'h7700;
    localparam logic [15:0] MASK_LOW_TWO    = 16'h0077;
    localparam logic [15:0] STATUS_MASK     = 16'h0F7F;
endpackage

// ===== src/ipc_prio_config.sv
// Priority configuration registers, arbitration and level/vector status for PWM, comparator and ADC pair sources.
// Summary of operation
// - Field value is source priority, seven highest.
// - Zero field disables the source entirely.
// - Every priority field resets to four.
// - Unimplemented bits read zero, ignore writes.
// - Fields at 14-12, 10-8, 6-4, 2-0.
// - Separate field per PWM, comparator, ADC source.
// - Status bits 11-8 report new level.
// - Status bits 6-0 report vector minus eight.
// - Status read-only, resets to zero.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module ipc_prio_config (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic [19:0] src_req_in,
    input  wire logic [7:0]  src_vector_base_in,
    output logic      [3:0]  new_cpu_level_out,
    output logic      [6:0]  pending_vector_number_out,
    output logic             irq_pending_out
);
    // Source index map: 0..8 PWM gen 1..9, 9..11 comparator 2..4, 12..19 ADC pair 0..7.
    logic [2:0]  prio [ipc_pkg::NUM_SRC];
    logic [19:0] active;
    logic [3:0]  new_cpu_level;
    logic [6:0]  pending_vector_number;
    logic [3:0]  next_level;
    logic [6:0]  next_vector;
    logic        next_found;
    logic [15:0] next_rdata;

    // Register that holds the field of every source.
    function automatic logic [3:0] src_reg(input int i);
        logic [3:0] r;
        r = ipc_pkg::OFS_ADC_C;
        case (i)
            0:       r = ipc_pkg::OFS_PWM_A;
            1:       r = ipc_pkg::OFS_PWM_A;
            2:       r = ipc_pkg::OFS_PWM_B;
            3:       r = ipc_pkg::OFS_PWM_B;
            4:       r = ipc_pkg::OFS_PWM_B;
            5:       r = ipc_pkg::OFS_PWM_B;
            6:       r = ipc_pkg::OFS_PWM_CMP;
            7:       r = ipc_pkg::OFS_PWM_CMP;
            8:       r = ipc_pkg::OFS_PWM_CMP;
            9:       r = ipc_pkg::OFS_PWM_CMP;
            10:      r = ipc_pkg::OFS_CMP;
            11:      r = ipc_pkg::OFS_CMP;
            12:      r = ipc_pkg::OFS_ADC_A;
            13:      r = ipc_pkg::OFS_ADC_A;
            14:      r = ipc_pkg::OFS_ADC_B;
            15:      r = ipc_pkg::OFS_ADC_B;
            16:      r = ipc_pkg::OFS_ADC_B;
            17:      r = ipc_pkg::OFS_ADC_B;
            18:      r = ipc_pkg::OFS_ADC_C;
            19:      r = ipc_pkg::OFS_ADC_C;
            default: r = ipc_pkg::OFS_ADC_C;
        endcase
        return r;
    endfunction

    // Field position of every source within its register.
    function automatic int src_lsb(input int i);
        int pos;
        pos = ipc_pkg::FLD0_LSB;
        case (i)
            0:       pos = ipc_pkg::FLD2_LSB;
            1:       pos = ipc_pkg::FLD3_LSB;
            2:       pos = ipc_pkg::FLD0_LSB;
            3:       pos = ipc_pkg::FLD1_LSB;
            4:       pos = ipc_pkg::FLD2_LSB;
            5:       pos = ipc_pkg::FLD3_LSB;
            6:       pos = ipc_pkg::FLD0_LSB;
            7:       pos = ipc_pkg::FLD1_LSB;
            8:       pos = ipc_pkg::FLD2_LSB;
            9:       pos = ipc_pkg::FLD3_LSB;
            10:      pos = ipc_pkg::FLD0_LSB;
            11:      pos = ipc_pkg::FLD1_LSB;
            12:      pos = ipc_pkg::FLD2_LSB;
            13:      pos = ipc_pkg::FLD3_LSB;
            14:      pos = ipc_pkg::FLD0_LSB;
            15:      pos = ipc_pkg::FLD1_LSB;
            16:      pos = ipc_pkg::FLD2_LSB;
            17:      pos = ipc_pkg::FLD3_LSB;
            18:      pos = ipc_pkg::FLD0_LSB;
            19:      pos = ipc_pkg::FLD1_LSB;
            default: pos = ipc_pkg::FLD0_LSB;
        endcase
        return pos;
    endfunction

    for (genvar g = 0; g < ipc_pkg::NUM_SRC; g++) begin : g_src
        localparam int LSB = src_lsb(g);
        ipc_prio_field u_field (
            .clk_in     (clk_in),
            .resetn_in  (resetn_in),
            .wr_in      (wr_in && (addr_in == src_reg(g))),
            .wdata_in   (wdata_in[LSB +: 3]),
            .req_in     (src_req_in[g]),
            .prio_out   (prio[g]),
            .active_out (active[g])
        );
    end

    // Highest priority wins; among equal priorities the lower source index wins.
    always_comb begin
        next_level = ipc_pkg::LEVEL_RESET;
        next_vector = ipc_pkg::VEC_RESET;
        next_found = 1'b0;
        for (int i = ipc_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (active[i] && ({1'b0, prio[i]} >= next_level)) begin
                next_level = {1'b0, prio[i]};
                next_vector = 7'(src_vector_base_in + 8'(i) - ipc_pkg::VEC_BASE);
                next_found = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            new_cpu_level <= ipc_pkg::LEVEL_RESET;
            pending_vector_number <= ipc_pkg::VEC_RESET;
            irq_pending_out <= 1'b0;
        end else begin
            irq_pending_out <= next_found;
            if (next_found) begin
                new_cpu_level <= next_level;
                pending_vector_number <= next_vector;
            end
        end
    end

    assign new_cpu_level_out = new_cpu_level;
    assign pending_vector_number_out = pending_vector_number;

    // Read data assembles the fields; unimplemented bits stay zero.
    always_comb begin
        next_rdata = 16'h0000;
        if (addr_in == ipc_pkg::OFS_STATUS) begin
            next_rdata[ipc_pkg::LEVEL_LSB +: 4] = new_cpu_level;
            next_rdata[ipc_pkg::VEC_LSB +: 7] = pending_vector_number;
        end else begin
            for (int i = 0; i < ipc_pkg::NUM_SRC; i++) begin
                if (addr_in == src_reg(i)) begin
                    next_rdata[src_lsb(i) +: 3] = prio[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= 16'h0000;
        end
    end

    // Read slot that follows a read strobe to the status register.
    sequence s_status_read;
        $past(rd_in) && ($past(addr_in) == ipc_pkg::OFS_STATUS);
    endsequence

    // A request that wins arbitration in this cycle.
    sequence s_new_winner;
        next_found;
    endsequence

    a_status_readonly: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (wr_in && addr_in == ipc_pkg::OFS_STATUS && !$past(irq_pending_out) && !irq_pending_out)
        |=> $stable(new_cpu_level))
        else $error("status level changed by write");
    a_unimpl_zero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(rd_in) && $past(addr_in) == ipc_pkg::OFS_PWM_B
        |-> (rdata_out & ~ipc_pkg::MASK_FOUR) == 16'h0000)
        else $error("unimplemented bits read nonzero");
    a_status_mask: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_status_read |-> (rdata_out & ~ipc_pkg::STATUS_MASK) == 16'h0000)
        else $error("status reserved bits nonzero");
    a_level_track: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_new_winner |=> new_cpu_level == $past(next_level))
        else $error("level not updated on new request");
    a_level_nonzero: assert property (@(posedge clk_in) disable iff (!resetn_in)
        irq_pending_out |-> new_cpu_level != 4'h0)
        else $error("pending request at level zero");
    a_write_field: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_in && addr_in == ipc_pkg::OFS_PWM_A |=> prio[0] == $past(wdata_in[10:8]))
        else $error("pwm gen1 field not written");
    a_rd_fresh: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside read slot");
    a_status_reset: assert property (@(posedge clk_in)
        !resetn_in |=> new_cpu_level == ipc_pkg::LEVEL_RESET && pending_vector_number == ipc_pkg::VEC_RESET)
        else $error("status not zero after reset");

    // Status read data must show the values held before the read edge.
    a_read_level: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_status_read |-> rdata_out[ipc_pkg::LEVEL_LSB +: 4] == $past(new_cpu_level))
        else $error("status read level mismatch");

    a_read_vector: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_status_read |-> rdata_out[ipc_pkg::VEC_LSB +: 7] == $past(pending_vector_number))
        else $error("status read vector mismatch");

    a_vector_track: assert property (@(posedge clk_in) disable iff (!resetn_in)
        s_new_winner |=> pending_vector_number == $past(next_vector))
        else $error("vector not updated on new request");

    a_hold_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !next_found |=> $stable(new_cpu_level) && $stable(pending_vector_number))
        else $error("status changed without a request");

    a_irq_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
        1'b1 |=> irq_pending_out == $past(next_found))
        else $error("pending flag does not follow requests");

    // Unimplemented bits of every priority register read zero.
    a_unimpl_pwm_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(rd_in) && $past(addr_in) == ipc_pkg::OFS_PWM_A
        |-> (rdata_out & ~ipc_pkg::MASK_HIGH_TWO) == 16'h0000)
        else $error("pwm register a spare bits nonzero");

    a_unimpl_pwm_cmp: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(rd_in) && $past(addr_in) == ipc_pkg::OFS_PWM_CMP
        |-> (rdata_out & ~ipc_pkg::MASK_FOUR) == 16'h0000)
        else $error("pwm comparator register spare bits nonzero");

    a_unimpl_cmp: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(rd_in) && $past(addr_in) == ipc_pkg::OFS_CMP
        |-> (rdata_out & ~ipc_pkg::MASK_LOW_TWO) == 16'h0000)
        else $error("comparator register spare bits nonzero");

    a_unimpl_adc_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(rd_in) && $past(addr_in) == ipc_pkg::OFS_ADC_A
        |-> (rdata_out & ~ipc_pkg::MASK_HIGH_TWO) == 16'h0000)
        else $error("adc register a spare bits nonzero");

    a_unimpl_adc_b: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(rd_in) && $past(addr_in) == ipc_pkg::OFS_ADC_B
        |-> (rdata_out & ~ipc_pkg::MASK_FOUR) == 16'h0000)
        else $error("adc register b spare bits nonzero");

    a_unimpl_adc_c: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $past(rd_in) && $past(addr_in) == ipc_pkg::OFS_ADC_C
        |-> (rdata_out & ~ipc_pkg::MASK_LOW_TWO) == 16'h0000)
        else $error("adc register c spare bits nonzero");

    // One field of every register lands at its own bit position.
    a_write_pwm_b: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_in && addr_in == ipc_pkg::OFS_PWM_B |=> prio[2] == $past(wdata_in[2:0]))
        else $error("pwm gen3 field not written");

    a_write_cmp2: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_in && addr_in == ipc_pkg::OFS_PWM_CMP |=> prio[9] == $past(wdata_in[14:12]))
        else $error("comparator2 field not written");

    a_write_cmp4: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_in && addr_in == ipc_pkg::OFS_CMP |=> prio[11] == $past(wdata_in[6:4]))
        else $error("comparator4 field not written");

    a_write_pair1: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_in && addr_in == ipc_pkg::OFS_ADC_A |=> prio[13] == $past(wdata_in[14:12]))
        else $error("adc pair1 field not written");

    a_write_pair2: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_in && addr_in == ipc_pkg::OFS_ADC_B |=> prio[14] == $past(wdata_in[2:0]))
        else $error("adc pair2 field not written");

    a_write_pair7: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_in && addr_in == ipc_pkg::OFS_ADC_C |=> prio[19] == $past(wdata_in[6:4]))
        else $error("adc pair7 field not written");
endmodule // ipc_prio_config

// ===== src/ipc_prio_field.sv
// One three-bit source priority field with reset value and enable decode.
`timescale 1ns/1ps
module ipc_prio_field (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       wr_in,
    input  wire logic [2:0] wdata_in,
    input  wire logic       req_in,
    output logic      [2:0] prio_out,
    output logic            active_out
);
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            prio_out <= ipc_pkg::PRIO_RESET;
        end else if (wr_in) begin
            prio_out <= wdata_in;
        end
    end

    // A zero field masks the request completely.
    assign active_out = req_in && (prio_out != ipc_pkg::PRIO_OFF);

    a_zero_blocks: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (prio_out == ipc_pkg::PRIO_OFF) |-> !active_out)
        else $error("disabled source presented");
    a_reset_four: assert property (@(posedge clk_in)
        !resetn_in |=> prio_out == ipc_pkg::PRIO_RESET)
        else $error("priority field not four after reset");
endmodule // ipc_prio_field
